// File: core/dtoei_tx.sv
//
// Purpose: transmit ds3 overhead generation, alarm insertion, error insertion
// Assumes: one line bit per cycle with in_valid high, in_frame_start on X1
// Notes: output is one cycle behind the input
`timescale 1ns/1ps
module dtoei_tx (
  input wire logic clock,
  input wire logic rst,
  input wire logic [10:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic cbit_mode,
  input wire logic manual_err_input,
  input wire logic rx_alarm,
  input wire logic rx_block_err,
  input wire logic in_bit,
  input wire logic in_valid,
  input wire logic in_frame_start,
  output logic out_bit,
  output logic out_valid,
  output logic out_overhead
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] einj_reg, einj_next;
  logic [15:0] rdata_reg, rdata_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    einj_next = einj_reg;
    rdata_next = rdata_reg;
    if (reg_wr && reg_addr == dtoei_pkg::ADDR_TX_CTRL) begin
      ctrl_next = reg_wdata & dtoei_pkg::CTRL_WMASK;
    end
    if (reg_wr && reg_addr == dtoei_pkg::ADDR_TX_EINJ) begin
      einj_next = reg_wdata & dtoei_pkg::EINJ_WMASK;
    end
    if (reg_rd) begin
      case (reg_addr)
        dtoei_pkg::ADDR_TX_CTRL: rdata_next = ctrl_reg;
        dtoei_pkg::ADDR_TX_EINJ: rdata_next = einj_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= dtoei_pkg::CTRL_RESET;
      einj_reg <= dtoei_pkg::EINJ_RESET;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      einj_reg <= einj_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // manual pin synchroniser and trigger edge
  logic man_meta_reg, man_sync_reg, trig_prev_reg;
  logic trig_src, trig_edge;

  // changing the select while a source is high makes a false edge
  assign trig_src = einj_reg[dtoei_pkg::EINJ_SRC] ? man_sync_reg :
                    einj_reg[dtoei_pkg::EINJ_SINGLE];
  assign trig_edge = trig_src && !trig_prev_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      man_meta_reg <= 1'b0;
      man_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      man_meta_reg <= manual_err_input;
      man_sync_reg <= man_meta_reg;
      trig_prev_reg <= trig_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame position
  logic [6:0] bit_cnt_reg, bit_cnt_next, cur_bit;
  logic [2:0] blk_cnt_reg, blk_cnt_next, cur_blk;
  logic [2:0] sub_cnt_reg, sub_cnt_next, cur_sub;
  dtoei_pkg::dtoei_oh_t kind;

  function automatic dtoei_pkg::dtoei_oh_t oh_kind(
    input logic [6:0] b, input logic [2:0] k, input logic [2:0] s);
    if (b != 7'd0) begin
      oh_kind = dtoei_pkg::DTOEI_OH_NONE;
    end else if (k[0]) begin
      oh_kind = dtoei_pkg::DTOEI_OH_F;
    end else if (k != 3'd0) begin
      oh_kind = dtoei_pkg::DTOEI_OH_C;
    end else if (s < dtoei_pkg::SUB_P1) begin
      oh_kind = dtoei_pkg::DTOEI_OH_X;
    end else if (s < dtoei_pkg::SUB_M1) begin
      oh_kind = dtoei_pkg::DTOEI_OH_P;
    end else begin
      oh_kind = dtoei_pkg::DTOEI_OH_M;
    end
  endfunction : oh_kind

  function automatic logic at_pos(
    input logic [6:0] b, input logic [2:0] k, input logic [2:0] s,
    input logic [2:0] want_k, input logic [2:0] want_s);
    at_pos = (b == 7'd0) && (k == want_k) && (s == want_s);
  endfunction : at_pos

  assign cur_bit = in_frame_start ? 7'd0 : bit_cnt_reg;
  assign cur_blk = in_frame_start ? 3'd0 : blk_cnt_reg;
  assign cur_sub = in_frame_start ? 3'd0 : sub_cnt_reg;
  assign kind = oh_kind(cur_bit, cur_blk, cur_sub);

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    blk_cnt_next = blk_cnt_reg;
    sub_cnt_next = sub_cnt_reg;
    if (in_valid) begin
      bit_cnt_next = cur_bit + 7'd1;
      blk_cnt_next = cur_blk;
      sub_cnt_next = cur_sub;
      if (cur_bit == dtoei_pkg::BLOCK_LAST) begin
        bit_cnt_next = 7'd0;
        blk_cnt_next = cur_blk + 3'd1;
        if (cur_blk == dtoei_pkg::BLOCK_IDX_LAST) begin
          sub_cnt_next = (cur_sub == dtoei_pkg::SUB_LAST) ? 3'd0 :
                         cur_sub + 3'd1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bit_cnt_reg <= 7'd0;
      blk_cnt_reg <= 3'd0;
      sub_cnt_reg <= 3'd0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      blk_cnt_reg <= blk_cnt_next;
      sub_cnt_reg <= sub_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error arming
  logic frame_pos, p_opp, cp_opp, fb_opp, fr_opp;
  logic p_fire, cp_fire, fb_fire, fr_fire;
  logic fr_m_kind, fr_busy;
  dtoei_pkg::dtoei_fe_t fe_type;

  assign fe_type = dtoei_pkg::dtoei_fe_t'(
    einj_reg[dtoei_pkg::EINJ_FT_HI:dtoei_pkg::EINJ_FT_LO]);
  assign frame_pos = in_valid && cur_bit == 7'd0 && cur_blk == 3'd0 &&
                     cur_sub == 3'd0;
  // p, cp, fb opportunities are the first bit of their group; framing takes the next F or M bit
  assign p_opp = in_valid && at_pos(cur_bit, cur_blk, cur_sub, 3'd0,
                                    dtoei_pkg::SUB_P1);
  assign cp_opp = in_valid && cbit_mode && at_pos(cur_bit, cur_blk, cur_sub,
                  dtoei_pkg::BLK_C1, dtoei_pkg::SUB_CP);
  assign fb_opp = in_valid && cbit_mode && at_pos(cur_bit, cur_blk, cur_sub,
                  dtoei_pkg::BLK_C1, dtoei_pkg::SUB_FEBE);
  // burst kind from the type field
  assign fr_m_kind = fe_type == dtoei_pkg::DTOEI_FE_MBIT ||
                     fe_type == dtoei_pkg::DTOEI_FE_OOMF;
  assign fr_opp = in_valid && !fr_busy &&
                  (fr_m_kind ? kind == dtoei_pkg::DTOEI_OH_M :
                               kind == dtoei_pkg::DTOEI_OH_F);

  dtoei_err_arm u_arm_p (
    .clock(clock), .rst(rst),
    .enable(einj_reg[dtoei_pkg::EINJ_P_EN]),
    .continuous(einj_reg[dtoei_pkg::EINJ_P_CONT]),
    .trigger(trig_edge), .opportunity(p_opp), .fire(p_fire));
  dtoei_err_arm u_arm_cp (
    .clock(clock), .rst(rst),
    .enable(einj_reg[dtoei_pkg::EINJ_CP_EN]),
    .continuous(einj_reg[dtoei_pkg::EINJ_CP_CONT]),
    .trigger(trig_edge), .opportunity(cp_opp), .fire(cp_fire));
  dtoei_err_arm u_arm_fb (
    .clock(clock), .rst(rst),
    .enable(einj_reg[dtoei_pkg::EINJ_FB_EN]),
    .continuous(einj_reg[dtoei_pkg::EINJ_FB_CONT]),
    .trigger(trig_edge), .opportunity(fb_opp), .fire(fb_fire));
  // framing errors; continuous has no bit, so single only
  dtoei_err_arm u_arm_fr (
    .clock(clock), .rst(rst),
    .enable(einj_reg[dtoei_pkg::EINJ_FR_EN]),
    .continuous(1'b0),
    .trigger(trig_edge), .opportunity(fr_opp), .fire(fr_fire));

  ////////////////////////////////////////////////////////////////////////////
  // datapath
  logic [2:0] frame_err_reg, frame_err_next; // p, cp, fb held for the frame
  logic [3:0] fr_left_reg, fr_left_next;
  logic fr_m_reg, fr_m_next;
  logic par_acc_reg, par_acc_next, par_prev_reg, par_prev_next;
  logic febe_pend_reg, febe_pend_next, febe_now_reg, febe_now_next;
  logic out_bit_next;
  logic ctl_fgd, ctl_pgen, ctl_cgd, ctl_ais, ctl_idle;

  assign fr_busy = fr_left_reg != 4'h0;
  assign ctl_fgd = ctrl_reg[dtoei_pkg::CTRL_FGD];
  assign ctl_pgen = ctrl_reg[dtoei_pkg::CTRL_PGEN];
  assign ctl_cgd = ctrl_reg[dtoei_pkg::CTRL_CGD];
  assign ctl_ais = ctrl_reg[dtoei_pkg::CTRL_AIS];
  assign ctl_idle = ctrl_reg[dtoei_pkg::CTRL_IDLE];

  always_comb begin
    logic v;
    logic [6:0] idx;
    logic fr_hit, c41;
    v = in_bit;
    idx = cur_bit - 7'd1;
    c41 = at_pos(cur_bit, cur_blk, cur_sub, dtoei_pkg::BLK_C1,
                 dtoei_pkg::SUB_FEBE);
    fr_hit = fr_busy && (fr_m_reg ? kind == dtoei_pkg::DTOEI_OH_M :
                                    kind == dtoei_pkg::DTOEI_OH_F);
    frame_err_next = frame_pos ? 3'h0 : frame_err_reg;
    frame_err_next = frame_err_next | {p_fire, cp_fire, fb_fire};
    fr_left_next = fr_left_reg;
    fr_m_next = fr_m_reg;
    // receive errors set, C41 consumes; set wins
    febe_pend_next = (febe_pend_reg && !(in_valid && c41)) || rx_block_err;
    febe_now_next = (in_valid && c41) ? febe_pend_reg : febe_now_reg;
    case (kind)
      dtoei_pkg::DTOEI_OH_X: begin
        if (!ctl_fgd) begin
          v = ctrl_reg[dtoei_pkg::CTRL_RDI_DEF] ?
              !ctrl_reg[dtoei_pkg::CTRL_RDI_VAL] : !rx_alarm;
        end
      end
      dtoei_pkg::DTOEI_OH_P: begin
        if (!ctl_fgd || ctl_pgen) begin
          v = par_prev_reg;
        end
        // invert both P-bits of the frame
        if (p_fire || frame_err_reg[2]) begin
          v = !v;
        end
      end
      dtoei_pkg::DTOEI_OH_M: begin
        if (!ctl_fgd) begin
          v = cur_sub == dtoei_pkg::SUB_M2;
        end
      end
      dtoei_pkg::DTOEI_OH_F: begin
        if (!ctl_fgd) begin
          v = cur_blk == dtoei_pkg::BLK_F1 || cur_blk == dtoei_pkg::BLK_F4;
        end
      end
      dtoei_pkg::DTOEI_OH_C: begin
        // pass-through when frame generation is off
        if (!ctl_fgd && cbit_mode) begin
          if (cur_sub == dtoei_pkg::SUB_CP) begin
            v = par_prev_reg ^ (cp_fire || frame_err_reg[1]);
          end else if (cur_sub == dtoei_pkg::SUB_FEBE) begin
            v = ctrl_reg[dtoei_pkg::CTRL_FEBE_DEF] ?
                !ctrl_reg[dtoei_pkg::CTRL_FEBE_VAL] :
                !(c41 ? febe_pend_reg : febe_now_reg);
            if (fb_fire || frame_err_reg[0]) begin
              v = 1'b0;
            end
          end else begin
            v = 1'b1;
          end
        end else if (!ctl_fgd && !ctl_cgd) begin
          v = 1'b0;
        end
      end
      default: begin
        if (ctl_ais) begin
          v = !cur_bit[0];
        end else if (ctl_idle) begin
          v = !idx[1];
        end
      end
    endcase
    // framing burst: first bit on fire, rest on later matches
    if (fr_fire) begin
      v = !v;
      fr_m_next = fr_m_kind;
      case (fe_type)
        dtoei_pkg::DTOEI_FE_SEF: fr_left_next = dtoei_pkg::SEF_F_BITS - 4'h1;
        dtoei_pkg::DTOEI_FE_OOMF: fr_left_next = dtoei_pkg::OOMF_M_BITS - 4'h1;
        default: fr_left_next = 4'h0;
      endcase
    end else if (in_valid && fr_hit) begin
      v = !v;
      fr_left_next = fr_left_reg - 4'h1;
    end
    // running parity over transmitted payload bits
    par_acc_next = par_acc_reg;
    par_prev_next = par_prev_reg;
    if (frame_pos) begin
      par_prev_next = par_acc_reg;
      par_acc_next = 1'b0;
    end else if (in_valid && kind == dtoei_pkg::DTOEI_OH_NONE) begin
      par_acc_next = par_acc_reg ^ v;
    end
    out_bit_next = in_valid ? v : out_bit;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      frame_err_reg <= 3'h0;
      fr_left_reg <= 4'h0;
      fr_m_reg <= 1'b0;
      par_acc_reg <= 1'b0;
      par_prev_reg <= 1'b0;
      febe_pend_reg <= 1'b0;
      febe_now_reg <= 1'b0;
      out_bit <= 1'b0;
      out_valid <= 1'b0;
      out_overhead <= 1'b0;
    end else begin
      frame_err_reg <= frame_err_next;
      fr_left_reg <= fr_left_next;
      fr_m_reg <= fr_m_next;
      par_acc_reg <= par_acc_next;
      par_prev_reg <= par_prev_next;
      febe_pend_reg <= febe_pend_next;
      febe_now_reg <= febe_now_next;
      out_bit <= out_bit_next;
      out_valid <= in_valid;
      out_overhead <= in_valid && kind != dtoei_pkg::DTOEI_OH_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence x_manual_s;
    in_valid && kind == dtoei_pkg::DTOEI_OH_X && !ctl_fgd &&
    ctrl_reg[dtoei_pkg::CTRL_RDI_DEF];
  endsequence

  rdi_manual_a: assert property (
    x_manual_s |=> out_bit == !$past(ctrl_reg[dtoei_pkg::CTRL_RDI_VAL]))
    else $error("manual X-bit value wrong");

  rdi_auto_a: assert property (
    in_valid && kind == dtoei_pkg::DTOEI_OH_X && !ctl_fgd &&
    !ctrl_reg[dtoei_pkg::CTRL_RDI_DEF] |=> out_bit == !$past(rx_alarm))
    else $error("automatic X-bit value wrong");

  pbit_pass_a: assert property (
    in_valid && kind == dtoei_pkg::DTOEI_OH_P && ctl_fgd && !ctl_pgen &&
    !p_fire && !frame_err_reg[2] |=> out_bit == $past(in_bit))
    else $error("P-bit not passed through");

  pbit_gen_a: assert property (
    in_valid && kind == dtoei_pkg::DTOEI_OH_P && ctl_pgen && !p_fire &&
    !frame_err_reg[2] |=> out_bit == $past(par_prev_reg))
    else $error("P-bit not generated");

  m23_czero_a: assert property (
    in_valid && kind == dtoei_pkg::DTOEI_OH_C && !cbit_mode && !ctl_fgd &&
    !ctl_cgd && !fr_busy |=> !out_bit)
    else $error("M23 C-bit not zero");

  febe_manual_a: assert property (
    in_valid && cbit_mode && !ctl_fgd && kind == dtoei_pkg::DTOEI_OH_C &&
    cur_sub == dtoei_pkg::SUB_FEBE && ctrl_reg[dtoei_pkg::CTRL_FEBE_DEF] &&
    !fb_fire && !frame_err_reg[0]
    |=> out_bit == !$past(ctrl_reg[dtoei_pkg::CTRL_FEBE_VAL]))
    else $error("manual block error bit wrong");

  ais_payload_a: assert property (
    in_valid && kind == dtoei_pkg::DTOEI_OH_NONE && ctl_ais
    |=> out_bit == !$past(cur_bit[0]))
    else $error("AIS pattern wrong");

  idle_payload_a: assert property (
    in_valid && kind == dtoei_pkg::DTOEI_OH_NONE && !ctl_ais && ctl_idle &&
    cur_bit == 7'd1 |=> out_bit ##1 (!in_valid || out_bit))
    else $error("idle pattern wrong");

  trig_select_a: assert property (
    einj_reg[dtoei_pkg::EINJ_SRC] && $stable(einj_reg) && !trig_prev_reg &&
    man_sync_reg |-> trig_edge)
    else $error("pin trigger edge missed");

endmodule : dtoei_tx

// File: core/dtoei_pkg.sv
//
// Purpose: shared constants for the transmit ds3 overhead and error block
// Assumes: one bit per valid cycle, 16-bit register port
// Notes: offsets are the printed register addresses
//
package dtoei_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int ADDR_W = 11;
  localparam logic [10:0] ADDR_TX_CTRL = 11'h118;
  localparam logic [10:0] ADDR_TX_EINJ = 11'h11A;
  localparam logic [10:0] ADDR_RSVD_A = 11'h11C;
  localparam logic [10:0] ADDR_RSVD_B = 11'h11E;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] EINJ_RESET = 16'h0000;
  // writable bits; all others read as zero
  localparam logic [15:0] CTRL_WMASK = 16'h1C3F;
  localparam logic [15:0] EINJ_WMASK = 16'h0F7F;

  ////////////////////////////////////////////////////////////////////////////
  // tx_framer_control fields
  localparam int CTRL_PGEN = 12;
  localparam int CTRL_IDLE = 11;
  localparam int CTRL_CGD = 10;
  localparam int CTRL_FEBE_VAL = 5;
  localparam int CTRL_FEBE_DEF = 4;
  localparam int CTRL_RDI_VAL = 3;
  localparam int CTRL_RDI_DEF = 2;
  localparam int CTRL_FGD = 1;
  localparam int CTRL_AIS = 0;

  // tx_error_injection fields
  localparam int EINJ_CP_CONT = 11;
  localparam int EINJ_CP_EN = 10;
  localparam int EINJ_FB_CONT = 9;
  localparam int EINJ_FB_EN = 8;
  localparam int EINJ_P_CONT = 6;
  localparam int EINJ_P_EN = 5;
  localparam int EINJ_FT_HI = 4;
  localparam int EINJ_FT_LO = 3;
  localparam int EINJ_FR_EN = 2;
  localparam int EINJ_SINGLE = 1;
  localparam int EINJ_SRC = 0;

  ////////////////////////////////////////////////////////////////////////////
  // frame geometry: 7 subframes of 8 blocks of 85 bits
  localparam logic [6:0] BLOCK_LAST = 7'd84;
  localparam logic [2:0] BLOCK_IDX_LAST = 3'd7;
  localparam logic [2:0] SUB_LAST = 3'd6;
  localparam logic [2:0] SUB_P1 = 3'd2;
  localparam logic [2:0] SUB_P2 = 3'd3;
  localparam logic [2:0] SUB_M1 = 3'd4;
  localparam logic [2:0] SUB_M2 = 3'd5;
  localparam logic [2:0] SUB_CP = 3'd2;
  localparam logic [2:0] SUB_FEBE = 3'd3;
  localparam logic [2:0] SUB_AIC = 3'd0;
  localparam logic [2:0] BLK_C1 = 3'd2;
  localparam logic [2:0] BLK_F1 = 3'd1;
  localparam logic [2:0] BLK_F4 = 3'd7;

  // framing burst lengths, counted in bits of the chosen kind
  localparam logic [3:0] SEF_F_BITS = 4'h3;
  localparam logic [3:0] OOMF_M_BITS = 4'hC;

  typedef enum logic [1:0] {
    DTOEI_FE_FBIT = 2'h0,
    DTOEI_FE_MBIT = 2'h1,
    DTOEI_FE_SEF = 2'h2,
    DTOEI_FE_OOMF = 2'h3
  } dtoei_fe_t;

  typedef enum logic [5:0] {
    DTOEI_OH_NONE = 6'h01,
    DTOEI_OH_X = 6'h02,
    DTOEI_OH_P = 6'h04,
    DTOEI_OH_M = 6'h08,
    DTOEI_OH_F = 6'h10,
    DTOEI_OH_C = 6'h20
  } dtoei_oh_t;

endpackage : dtoei_pkg

// File: core/dtoei_err_arm.sv
//
// Purpose: arms one error type and fires it at its next opportunity
// Assumes: trigger is a one-cycle rising-edge pulse
// Notes: several triggers before an opportunity collapse into one error
//
`timescale 1ns/1ps
module dtoei_err_arm (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic continuous,
  input wire logic trigger,
  input wire logic opportunity,
  output logic fire
);

  logic pending_reg;
  logic pending_next;

  ////////////////////////////////////////////////////////////////////////////
  // single pending flag
  // a new trigger in the consuming cycle keeps the flag: set wins
  always_comb begin
    if (!enable || continuous) begin
      pending_next = 1'b0;
    end else if (trigger) begin
      pending_next = 1'b1;
    end else if (opportunity) begin
      pending_next = 1'b0;
    end else begin
      pending_next = pending_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  assign fire = enable && opportunity && (continuous || pending_reg);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence armed_s;
    enable && !continuous && trigger && !opportunity;
  endsequence

  single_shot_a: assert property (
    armed_s ##1 (enable && !continuous && opportunity && !trigger)
      |-> fire ##1 !fire [*1] or (!opportunity ##0 1'b1))
    else $error("armed error not fired once");

  no_fire_off_a: assert property (
    !enable |-> !fire)
    else $error("error fired while disabled");

endmodule : dtoei_err_arm

// File: verif/dtoei_src.sv
//
// Purpose: framed random bit source feeding the tx block
// Assumes: 4760-bit frames, first bit is X1
// Notes: tidx, tbit and tval name the bit now on the block output
//
`timescale 1ns/1ps
module dtoei_src (
  input wire logic clock,
  input wire logic rst,
  output logic in_bit,
  output logic in_valid,
  output logic in_frame_start,
  output int tidx,
  output logic tbit,
  output logic tval
);
  int cur = 0;
  int nxt = 0;
  initial begin
    {in_bit, in_valid, in_frame_start, tbit, tval} = 5'h00;
    tidx = 0;
  end
  always @(posedge clock) begin
    tidx <= cur;
    tbit <= in_bit;
    tval <= in_valid;
    if (rst) begin
      in_valid <= 1'h0;
      nxt <= 0;
    end else begin
      in_valid <= 1'h1;
      in_frame_start <= nxt == 0;
      in_bit <= 1'($urandom);
      cur <= nxt;
      nxt <= nxt == 4759 ? 0 : nxt + 1;
    end
  end
endmodule : dtoei_src

// File: verif/dtoei_tx_tb_top.sv
//
// Purpose: self-checking bench for dtoei_tx
// Assumes: M23 format, then a short C-bit mode pass for block error bits
// Notes: generated P-bits are not compared; parity paths need a deeper model
//
`timescale 1ns/1ps
module dtoei_tx_tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [10:0] reg_addr = 11'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic manual_err_input = 1'h0;
  logic rx_alarm = 1'h0;
  logic cbm = 1'h0;
  logic rxe = 1'h0;
  logic [15:0] reg_rdata, cw, ew, rv, got;
  logic in_bit, in_valid, in_frame_start, out_bit, out_valid, out_overhead;
  logic tbit, tval, chk;
  logic [1:0] e;
  int tidx, b, k, s, ferr, merr;
  int errors = 0;
  int compares = 0;
  logic [10:0] ad [3] = '{11'h118, 11'h11A, 11'h11C};
  logic [15:0] mk [3] = '{16'h1C3F, 16'h0F7F, 16'h0000};
  logic [15:0] md [5] = '{16'h0000, 16'h0004, 16'h0801, 16'h0800, 16'h0002};
  logic [15:0] fe [4] = '{16'h0001, 16'h0000, 16'h0003, 16'h0000};
  logic [15:0] me [4] = '{16'h0000, 16'h0001, 16'h0000, 16'h000C};
  logic [15:0] cm [3] = '{16'h0000, 16'h0010, 16'h0010};

  dtoei_tx dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cbit_mode(cbm),
    .manual_err_input(manual_err_input), .rx_alarm(rx_alarm),
    .rx_block_err(rxe), .in_bit(in_bit), .in_valid(in_valid),
    .in_frame_start(in_frame_start), .out_bit(out_bit),
    .out_valid(out_valid), .out_overhead(out_overhead));
  dtoei_src src (.clock(clock), .rst(rst), .in_bit(in_bit),
    .in_valid(in_valid), .in_frame_start(in_frame_start), .tidx(tidx),
    .tbit(tbit), .tval(tval));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk16(input logic [15:0] g, input logic [15:0] x);
    compares++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED at %0t: word %h want %h", $time, g, x);
    end
  endtask : chk16
  task automatic chkb(input logic g, input logic x);
    compares++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED at %0t: bit %0d want %b", $time, tidx, x);
    end
  endtask : chkb
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(negedge clock);
    d = reg_rdata;
  endtask : rd
  // triggers land well clear of any F or M position
  task automatic align;
    for (int n = 0; n < 200 && tidx % 170 != 100; n++) @(negedge clock);
    if (tidx % 170 != 100) begin
      errors++;
      close_out();
    end
  endtask : align

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] exp_bit(int b, int k, int s, logic d);
    // alarm pattern wins, even payload positions carry ones
    if (b != 0 && cw[0]) return {1'h1, b % 2 == 0};
    if (b != 0 && cw[11]) return {1'h1, (b - 1) % 4 < 2};
    if (b != 0 || cw[1]) return {1'h1, d};
    if (cw[0] || cw[11]) return 2'h0;
    if (k == 0 && s < 2) return {1'h1, cw[2] ? !cw[3] : !rx_alarm};
    // M23 C-bits zero; C-bit mode fills spare C-bits with ones
    if (k % 2 == 0 && k != 0 && !cbm) return {1'h1, 1'h0};
    if (k % 2 == 0 && k != 0 && s != 2 && s != 3) return 2'h3;
    // block error bits; parity bits left out
    if (k % 2 == 0 && k != 0 && s == 3)
      return {1'h1, !ew[8] && (cw[4] ? !cw[5] : !rxe)};
    return 2'h0;
  endfunction : exp_bit

  always @(negedge clock) begin
    if (chk && !rst && tval) begin
      b = tidx % 85;
      k = (tidx / 85) % 8;
      s = tidx / 680;
      e = exp_bit(b, k, s, tbit);
      chkb(out_valid, tval);
      chkb(out_overhead, b == 0);
      if (e[1] && b != 0) chkb(out_bit, e[0]);
      if (e[1] && b == 0) chkb(out_bit, e[0]);
      if (b == 0 && !cw[1] && k % 2 == 1 && out_bit !== (k == 1 || k == 7))
        ferr++;
      if (b == 0 && !cw[1] && k == 0 && s > 3 && out_bit !== (s == 5))
        merr++;
    end
  end

  initial begin
    forever #2.5 clock = ~clock;
  end
  initial begin
    #480000;
    errors++;
    close_out();
  end
  initial begin
    {chk, cw} = 17'h00000;
    ew = 16'h0000;
    void'($urandom(63546));
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    foreach (ad[i]) begin
      rd(ad[i], got);
      chk16(got, 16'h0000);
      rv = 16'($urandom);
      wr(ad[i], rv);
      rd(ad[i], got);
      chk16(got, rv & mk[i]);
      wr(ad[i], 16'h0000);
    end
    $display("test registers done");
    foreach (md[i]) begin
      rx_alarm <= 1'($urandom);
      cw = md[i] | (16'($urandom) & 16'h0008);
      wr(11'h118, cw);
      repeat (200) @(posedge clock);
      ferr = 0;
      merr = 0;
      chk = 1'h1;
      repeat (4760) @(posedge clock);
      chk = 1'h0;
      chk16(16'(ferr + merr), 16'h0000);
      $display("test mode %0d done", i);
    end
    // long settle so no C41..C43 group straddles a setting change
    cbm <= 1'h1;
    foreach (cm[i]) begin
      rxe <= 1'(i == 0);
      cw = cm[i];
      ew = i == 2 ? 16'h0300 : 16'h0000;
      wr(11'h118, cw);
      wr(11'h11A, ew);
      repeat (600) @(posedge clock);
      chk = 1'h1;
      repeat (4760) @(posedge clock);
      chk = 1'h0;
      $display("test cbit mode %0d done", i);
    end
    wr(11'h11A, 16'h0000);
    ew = 16'h0000;
    cbm <= 1'h0;
    cw = 16'h0000;
    wr(11'h118, cw);
    repeat (200) @(posedge clock);
    chk = 1'h1;
    foreach (fe[i]) begin
      ferr = 0;
      merr = 0;
      align();
      wr(11'h11A, 16'h0004 | 16'(i << 3));
      wr(11'h11A, 16'h0006 | 16'(i << 3));
      wr(11'h11A, 16'h0004 | 16'(i << 3));
      wr(11'h11A, 16'h0006 | 16'(i << 3));
      repeat (i == 3 ? 24000 : 5000) @(posedge clock);
      chk16(16'(ferr), fe[i]);
      chk16(16'(merr), me[i]);
      $display("test framing type %0d done", i);
    end
    wr(11'h11A, 16'h0000);
    // select moved with both triggers low
    wr(11'h11A, 16'h0001);
    wr(11'h11A, 16'h0005);
    ferr = 0;
    wr(11'h11A, 16'h0007);
    align();
    @(posedge clock);
    manual_err_input <= 1'h1;
    repeat (8) @(posedge clock);
    manual_err_input <= 1'h0;
    repeat (5000) @(posedge clock);
    chk16(16'(ferr), 16'h0001);
    $display("test manual pin done");
    close_out();
  end
endmodule : dtoei_tx_tb_top
